//--- logic/pifb_pkg.sv
`default_nettype none
package pifb_pkg;
   // Bus geometry
   localparam int unsigned AXI_ADDR_W   = 8;
   localparam int unsigned AXI_DATA_W   = 32;
   localparam int unsigned FLAGS_W      = 8;
   localparam int unsigned N_CCP        = 4;
   localparam int unsigned CCP_MODE_W   = 2;

   // Register byte offsets
   localparam logic [7:0] FLAGS_OFS     = 8'h00;
   localparam logic [7:0] FLAGS_CLR_OFS = 8'h04;
   localparam logic [7:0] MASK_OFS      = 8'h08;
   localparam logic [7:0] MODE_OFS      = 8'h0C;

   // Reset values
   localparam logic [7:0] FLAGS_RESET   = 8'h00;
   localparam logic [7:0] MASK_RESET    = 8'h00;
   localparam logic [7:0] MODE_RESET    = 8'h00;

   // Flag bit positions
   localparam int unsigned BIT_CCP1     = 0;
   localparam int unsigned BIT_CCP4     = 3;
   localparam int unsigned BIT_T5_OVF   = 4;
   localparam int unsigned BIT_T5_GATE  = 5;
   localparam int unsigned BIT_CWG1     = 6;
   localparam int unsigned BIT_CWG2     = 7;

   // Channel mode codes
   localparam logic [1:0] MODE_OFF      = 2'h0;
   localparam logic [1:0] MODE_CAPTURE  = 2'h1;
   localparam logic [1:0] MODE_COMPARE  = 2'h2;
   localparam logic [1:0] MODE_PWM      = 2'h3;

   // Bus responses
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

//--- logic/pifb_edge_det.sv
`timescale 1ns/10ps
`default_nettype none
module pifb_edge_det #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Levels and their edges
   input  wire logic [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] prev_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         prev_reg <= '0;
      else
         prev_reg <= level;
   end

   assign rise = level & ~prev_reg;
   assign fall = prev_reg & ~level;
endmodule
`default_nettype wire

//--- logic/pifb_ccp_event_sel.sv
`timescale 1ns/10ps
`default_nettype none
module pifb_ccp_event_sel
#(
   parameter int unsigned N = 4
) (
   // Per-channel mode and raw events
   input  wire logic [N*2-1:0] mode,
   input  wire logic [N-1:0]   capture,
   input  wire logic [N-1:0]   compare_match,
   input  wire logic [N-1:0]   pwm_fall,
   // Selected flag events
   output logic      [N-1:0]   event_out
);
   import pifb_pkg::*;

   for (genvar i = 0; i < N; i++)
   begin : g_ch
      always_comb
      begin
         unique case (mode[i*2 +: 2])
            MODE_CAPTURE: event_out[i] = capture[i];        // [R04]
            MODE_COMPARE: event_out[i] = compare_match[i];  // [R05]
            MODE_PWM:     event_out[i] = pwm_fall[i];       // [R06]
            MODE_OFF:     event_out[i] = 1'b0;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- logic/pifb_top.sv
// Function
// R01: Each flag bit is set when its condition occurs, whatever any enable or mask bit says.
// R02: Software should clear a flag before enabling its interrupt so a stale event does not fire at once.
// R03: The timer5 overflow flag is set on overflow and is cleared only by software, never by hardware.
// R04: In capture mode, channel 4 sets its flag on each capture, held until software clears it.
// R05: In compare mode, channel 4 sets its flag on a compare match, held until software clears it.
// R06: In PWM mode, channel 4 sets its flag at the trailing edge of the output pulse, held until cleared.
// R07: Each waveform generator sets its flag on entering shutdown, timer5 gate sets its flag on going inactive.
`timescale 1ns/10ps
`default_nettype none
module pifb_top
(
   // Clock and reset
   input  wire logic                               aclk,
   input  wire logic                               aresetn,
   // AXI4-Lite write address
   input  wire logic [pifb_pkg::AXI_ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic [2:0]                         s_axi_awprot,
   input  wire logic                               s_axi_awvalid,
   output logic                                    s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [pifb_pkg::AXI_DATA_W-1:0]    s_axi_wdata,
   input  wire logic [pifb_pkg::AXI_DATA_W/8-1:0]  s_axi_wstrb,
   input  wire logic                               s_axi_wvalid,
   output logic                                    s_axi_wready,
   // AXI4-Lite write response
   output logic      [1:0]                         s_axi_bresp,
   output logic                                    s_axi_bvalid,
   input  wire logic                               s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [pifb_pkg::AXI_ADDR_W-1:0]    s_axi_araddr,
   input  wire logic [2:0]                         s_axi_arprot,
   input  wire logic                               s_axi_arvalid,
   output logic                                    s_axi_arready,
   // AXI4-Lite read data
   output logic      [pifb_pkg::AXI_DATA_W-1:0]    s_axi_rdata,
   output logic      [1:0]                         s_axi_rresp,
   output logic                                    s_axi_rvalid,
   input  wire logic                               s_axi_rready,
   // Interrupt sources
   input  wire logic                               cwg1_shutdown,
   input  wire logic                               cwg2_shutdown,
   input  wire logic                               timer5_overflow,
   input  wire logic                               timer5_gate,
   input  wire logic [pifb_pkg::N_CCP-1:0]         ccp_capture,
   input  wire logic [pifb_pkg::N_CCP-1:0]         ccp_compare_match,
   input  wire logic [pifb_pkg::N_CCP-1:0]         ccp_pwm_out,
   // Block outputs
   output logic [pifb_pkg::FLAGS_W-1:0]            peripheral_irq_flags_4,
   output logic [pifb_pkg::N_CCP*2-1:0]            ccp_mode_select,
   output logic                                    irq
);
   import pifb_pkg::*;

   logic                  awready_reg;
   logic                  wready_reg;
   logic                  aw_full_reg;
   logic                  w_full_reg;
   logic [AXI_ADDR_W-1:0] wr_addr_reg;
   logic [FLAGS_W-1:0]    wr_data_reg;
   logic                  wr_strb0_reg;
   logic                  bvalid_reg;
   logic [1:0]            bresp_reg;
   logic                  arready_reg;
   logic                  rvalid_reg;
   logic [AXI_DATA_W-1:0] rdata_reg;
   logic [1:0]            rresp_reg;
   logic [FLAGS_W-1:0]    flags_reg;
   logic [FLAGS_W-1:0]    flags_next;
   logic [FLAGS_W-1:0]    mask_reg;
   logic [N_CCP*2-1:0]    mode_reg;
   logic                  irq_reg;
   logic [FLAGS_W-1:0]    set_vec;
   logic [N_CCP-1:0]      ccp_event;
   logic [N_CCP-1:0]      pwm_fall;
   logic [1:0]            cwg_rise;
   logic                  gate_fall;
   logic                  do_write;
   logic                  wr_mapped;
   logic                  sw_wr;
   logic                  sw_clr;
   logic                  ovf_sw_clear;
   logic                  aw_hs;
   logic                  w_hs;
   logic                  ar_hs;
   logic [1:0]            u_unused_cwg_fall;
   logic                  u_unused_gate_rise;
   logic [N_CCP-1:0]      u_unused_pwm_rise;

   assign aw_hs    = s_axi_awvalid && awready_reg;
   assign w_hs     = s_axi_wvalid && wready_reg;
   assign ar_hs    = s_axi_arvalid && arready_reg;
   assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wr_mapped = (wr_addr_reg == FLAGS_OFS) || (wr_addr_reg == FLAGS_CLR_OFS) ||
                      (wr_addr_reg == MASK_OFS) || (wr_addr_reg == MODE_OFS);
   assign sw_wr    = do_write && wr_strb0_reg && (wr_addr_reg == FLAGS_OFS);
   assign sw_clr   = do_write && wr_strb0_reg && (wr_addr_reg == FLAGS_CLR_OFS);
   assign ovf_sw_clear = (sw_wr && !wr_data_reg[BIT_T5_OVF]) || (sw_clr && wr_data_reg[BIT_T5_OVF]);

   // Edge detection on level sources
   pifb_edge_det #(
      .WIDTH (N_CCP + 3)
   ) u_edges (
      .aclk    (aclk),
      .aresetn (aresetn),
      .level   ({cwg2_shutdown, cwg1_shutdown, timer5_gate, ccp_pwm_out}),
      .rise    ({cwg_rise, u_unused_gate_rise, u_unused_pwm_rise}),
      .fall    ({u_unused_cwg_fall, gate_fall, pwm_fall})
   );

   // Mode-dependent channel events
   pifb_ccp_event_sel #(
      .N (N_CCP)
   ) u_ccp_sel (
      .mode          (mode_reg),
      .capture       (ccp_capture),
      .compare_match (ccp_compare_match),
      .pwm_fall      (pwm_fall),
      .event_out     (ccp_event)
   );

   // Hardware set sources, never gated by mask
   always_comb
   begin
      set_vec                          = '0;
      set_vec[BIT_CCP4:BIT_CCP1]       = ccp_event;          // [R04] [R05] [R06]
      set_vec[BIT_T5_OVF]              = timer5_overflow;    // [R03]
      set_vec[BIT_T5_GATE]             = gate_fall;          // [R07]
      set_vec[BIT_CWG1]                = cwg_rise[0];        // [R07]
      set_vec[BIT_CWG2]                = cwg_rise[1];        // [R07]
   end

   // Software write or clear, hardware set wins
   always_comb
   begin
      flags_next = flags_reg;
      if (sw_wr)
         flags_next = wr_data_reg;
      else if (sw_clr)
         flags_next = flags_reg & ~wr_data_reg;
      flags_next = flags_next | set_vec;                     // [R01] [R03]
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flags_reg <= FLAGS_RESET;
      else
         flags_reg <= flags_next;
   end

   // Mask and mode registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mask_reg <= MASK_RESET;
         mode_reg <= MODE_RESET;
      end
      else if (do_write && wr_strb0_reg)
      begin
         if (wr_addr_reg == MASK_OFS)
            mask_reg <= wr_data_reg;
         if (wr_addr_reg == MODE_OFS)
            mode_reg <= wr_data_reg;
      end
   end

   // Level interrupt
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(flags_reg & mask_reg);
   end

   // Write address channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_reg <= 1'b0;
         aw_full_reg <= 1'b0;
         wr_addr_reg <= '0;
      end
      else if (aw_hs)
      begin
         awready_reg <= 1'b0;
         aw_full_reg <= 1'b1;
         wr_addr_reg <= {s_axi_awaddr[AXI_ADDR_W-1:2], 2'b00};
      end
      else if (do_write)
         aw_full_reg <= 1'b0;
      else if (!aw_full_reg && !bvalid_reg)
         awready_reg <= 1'b1;
   end

   // Write data channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wready_reg   <= 1'b0;
         w_full_reg   <= 1'b0;
         wr_data_reg  <= '0;
         wr_strb0_reg <= 1'b0;
      end
      else if (w_hs)
      begin
         wready_reg   <= 1'b0;
         w_full_reg   <= 1'b1;
         wr_data_reg  <= s_axi_wdata[FLAGS_W-1:0];
         wr_strb0_reg <= s_axi_wstrb[0];
      end
      else if (do_write)
         w_full_reg <= 1'b0;
      else if (!w_full_reg && !bvalid_reg)
         wready_reg <= 1'b1;
   end

   // Write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   // Read channel, data registered on address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= RESP_OKAY;
      end
      else if (ar_hs)
      begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rresp_reg   <= RESP_OKAY;
         unique case ({s_axi_araddr[AXI_ADDR_W-1:2], 2'b00})
            FLAGS_OFS,
            FLAGS_CLR_OFS: rdata_reg <= {{(AXI_DATA_W-FLAGS_W){1'b0}}, flags_reg};
            MASK_OFS:      rdata_reg <= {{(AXI_DATA_W-FLAGS_W){1'b0}}, mask_reg};
            MODE_OFS:      rdata_reg <= {{(AXI_DATA_W-N_CCP*2){1'b0}}, mode_reg};
            default:
            begin
               rdata_reg <= '0;
               rresp_reg <= RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_reg)
      begin
         if (s_axi_rready)
            rvalid_reg <= 1'b0;
      end
      else
         arready_reg <= 1'b1;
   end

   assign s_axi_awready          = awready_reg;
   assign s_axi_wready           = wready_reg;
   assign s_axi_bvalid           = bvalid_reg;
   assign s_axi_bresp            = bresp_reg;
   assign s_axi_arready          = arready_reg;
   assign s_axi_rvalid           = rvalid_reg;
   assign s_axi_rdata            = rdata_reg;
   assign s_axi_rresp            = rresp_reg;
   assign peripheral_irq_flags_4 = flags_reg;
   assign ccp_mode_select        = mode_reg;
   assign irq                    = irq_reg;

   // Checks
   a_set_any_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
      (set_vec != 8'h00) |=> ((flags_reg & $past(set_vec)) == $past(set_vec)))
      else $error("flag not set by its event");

   a_ovf_sw_only: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
      (flags_reg[BIT_T5_OVF] && !ovf_sw_clear) |=> flags_reg[BIT_T5_OVF])
      else $error("overflow flag cleared without software");

   a_ovf_sets: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
      timer5_overflow |=> flags_reg[BIT_T5_OVF])
      else $error("overflow did not set its flag");

   a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
      ((flags_reg & mask_reg) != 8'h00) |=> irq_reg)
      else $error("irq low with an unmasked flag set");

   a_irq_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
      ((flags_reg & mask_reg) == 8'h00) |=> !irq_reg)
      else $error("irq high with no unmasked flag set");

   a_ccp4_capture: assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
      (mode_reg[7:6] == MODE_CAPTURE && ccp_capture[BIT_CCP4]) |=> flags_reg[BIT_CCP4])
      else $error("capture did not set channel 4 flag");

   a_ccp4_compare: assert property (@(posedge aclk) disable iff (!aresetn) // [R05]
      (mode_reg[7:6] == MODE_COMPARE && ccp_compare_match[BIT_CCP4]) |=> flags_reg[BIT_CCP4])
      else $error("compare match did not set channel 4 flag");

   a_ccp4_pwm_edge: assert property (@(posedge aclk) disable iff (!aresetn) // [R06]
      ($past(aresetn) && mode_reg[7:6] == MODE_PWM && $fell(ccp_pwm_out[BIT_CCP4]))
      |=> flags_reg[BIT_CCP4])
      else $error("pwm trailing edge did not set channel 4 flag");

   a_cwg1_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
      ($past(aresetn) && $rose(cwg1_shutdown)) |=> flags_reg[BIT_CWG1])
      else $error("shutdown did not set generator 1 flag");

   a_cwg2_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
      ($past(aresetn) && $rose(cwg2_shutdown)) |=> flags_reg[BIT_CWG2])
      else $error("shutdown did not set generator 2 flag");

   a_gate_fall_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
      ($past(aresetn) && $fell(timer5_gate)) |=> flags_reg[BIT_T5_GATE])
      else $error("gate going inactive did not set its flag");
endmodule
`default_nettype wire

//--- test/pifb_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module pifb_top_tb;
   import pifb_pkg::*;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        cwg1 = 1'h0, cwg2 = 1'h0, t5_ovf = 1'h0, t5_gate = 1'h0;
   logic [3:0]  cap = 4'h0, cmp = 4'h0, pwm = 4'h0;
   logic [7:0]  flags, mode;
   int          errors = 0;
   int          n_tests = 0;

   always #25 aclk = ~aclk;

   pifb_top dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cwg1_shutdown(cwg1), .cwg2_shutdown(cwg2), .timer5_overflow(t5_ovf), .timer5_gate(t5_gate),
      .ccp_capture(cap), .ccp_compare_match(cmp), .ccp_pwm_out(pwm),
      .peripheral_irq_flags_4(flags), .ccp_mode_select(mode), .irq(irq)
   );

   task automatic test_done;
      if (errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic timeout_check(input int k);
      if (k >= 100)
      begin
         errors++;
         test_done();
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr_chk(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
      int k;
      k = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (k < 100)
      begin
         @(posedge aclk);
         k++;
         if (awready === 1'h1)
            awvalid <= 1'h0;
         if (wready === 1'h1)
            wvalid <= 1'h0;
         if (bvalid === 1'h1)
            break;
      end
      bready <= 1'h0;
      timeout_check(k);
      `CHK(bresp, er);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      int k;
      k = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (k < 100)
      begin
         @(posedge aclk);
         k++;
         if (arready === 1'h1)
            arvalid <= 1'h0;
         if (rvalid === 1'h1)
            break;
      end
      rready <= 1'h0;
      timeout_check(k);
      `CHK(rdata, {24'h000000, e});
      `CHK(rresp, er);
   endtask

   // One-cycle source pulse: 0 capture, 1 compare, 2 pwm output, 3 overflow
   task automatic src(input int s);
      @(posedge aclk);
      if (s == 0)
         cap <= 4'h8;
      else if (s == 1)
         cmp <= 4'h8;
      else if (s == 2)
         pwm <= 4'h8;
      else
         t5_ovf <= 1'h1;
      @(posedge aclk);
      cap <= 4'h0;
      cmp <= 4'h0;
      pwm <= 4'h0;
      t5_ovf <= 1'h0;
   endtask

   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      tick(2);
      rd_chk(FLAGS_OFS, FLAGS_RESET, RESP_OKAY);
      rd_chk(MASK_OFS, MASK_RESET, RESP_OKAY);
      rd_chk(MODE_OFS, MODE_RESET, RESP_OKAY);
      rd_chk(8'h10, 8'h00, RESP_SLVERR);
      wr_chk(8'h10, 8'hFF, RESP_SLVERR);
      // Overflow with every mask bit off still latches
      src(3);
      tick(2);
      `CHK(flags, 8'h10);
      `CHK(irq, 1'h0);
      tick(20);
      rd_chk(FLAGS_OFS, 8'h10, RESP_OKAY);
      wr_chk(FLAGS_CLR_OFS, 8'h10, RESP_OKAY);
      wr_chk(MASK_OFS, 8'h10, RESP_OKAY);
      tick(2);
      `CHK(irq, 1'h0);
      src(3);
      tick(3);
      `CHK(irq, 1'h1);
      wr_chk(FLAGS_OFS, 8'h00, RESP_OKAY);
      tick(2);
      `CHK(flags, 8'h00);
      `CHK(irq, 1'h0);
      // Shutdown entries and gate going inactive
      cwg1 <= 1'h1;
      tick(3);
      `CHK(flags, 8'h40);
      cwg2 <= 1'h1;
      t5_gate <= 1'h1;
      tick(3);
      `CHK(flags, 8'hC0);
      t5_gate <= 1'h0;
      cwg1 <= 1'h0;
      cwg2 <= 1'h0;
      tick(3);
      `CHK(flags, 8'hE0);
      `CHK(irq, 1'h0);
      wr_chk(FLAGS_CLR_OFS, 8'hE0, RESP_OKAY);
      rd_chk(FLAGS_OFS, 8'h00, RESP_OKAY);
      // Channel 4 event source follows its mode
      for (int m = 0; m < 4; m++)
      begin
         wr_chk(MODE_OFS, {m[1:0], 6'h00}, RESP_OKAY);
         `CHK(mode, {m[1:0], 6'h00});
         for (int s = 0; s < 3; s++)
         begin
            src(s);
            tick(10);
            rd_chk(FLAGS_OFS, (m == s + 1) ? 8'h08 : 8'h00, RESP_OKAY);
            wr_chk(FLAGS_OFS, 8'h00, RESP_OKAY);
         end
      end
      // Byte lane 0 off: write ignored
      wstrb <= 4'hE;
      wr_chk(MASK_OFS, 8'hFF, RESP_OKAY);
      wstrb <= 4'hF;
      rd_chk(MASK_OFS, 8'h10, RESP_OKAY);
      // Software write sets flags, clear alias reads them back
      wr_chk(FLAGS_OFS, 8'h0F, RESP_OKAY);
      rd_chk(FLAGS_CLR_OFS, 8'h0F, RESP_OKAY);
      `CHK(irq, 1'h0);
      wr_chk(MASK_OFS, 8'h01, RESP_OKAY);
      tick(2);
      `CHK(irq, 1'h1);
      // Reset in mid-run returns every register to its reset value
      aresetn <= 1'h0;
      tick(2);
      aresetn <= 1'h1;
      tick(2);
      `CHK(flags, FLAGS_RESET);
      `CHK(irq, 1'h0);
      rd_chk(MASK_OFS, MASK_RESET, RESP_OKAY);
      rd_chk(MODE_OFS, MODE_RESET, RESP_OKAY);
      test_done();
   end
endmodule
`default_nettype wire
